// File: rtl/bsis_sequencer.sv
// start-up sequencer: align or position detection, then open loop acceleration
`timescale 1ns/100ps
`default_nettype none
`include "bsis_params.svh"
module bsis_sequencer #(
  parameter int ALIGN_BASE_CYC = `BSIS_ALIGN_BASE_CYC,
  parameter int STEP_CYC = `BSIS_STEP_CYC,
  parameter int GAP_BASE_CYC = `BSIS_GAP_BASE_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic startReq,
  input wire logic restartReq,
  input wire logic currentAtThresh,
  input wire logic [7:0] supplyLevel,
  output logic [2:0] phaseHigh,
  output logic [2:0] phaseLow,
  output logic [3:0] currentThresh,
  output logic [7:0] currentLimit,
  output logic [15:0] dutyOut,
  output logic [2:0] driveState,
  output logic closedLoopGo,
  output logic busy
);
  // register offsets and layout
  localparam logic [7:0] OFS_B = `BSIS_OFS_B; // start current[1:0], ramp rate[4:2]
  localparam logic [7:0] OFS_C = `BSIS_OFS_C; // first order[2:0], second order[5:3]
  localparam logic [7:0] OFS_D = `BSIS_OFS_D; // handoff thresh[4:0]
  localparam logic [7:0] OFS_E = `BSIS_OFS_E; // align duration[2:0]
  localparam logic [7:0] OFS_F = `BSIS_OFS_F; // detect thresh[3:0], release[4], spacing[6:5]
  localparam logic [7:0] OFS_G = `BSIS_OFS_G; // lead angle[1:0]
  localparam logic [7:0] OFS_WRES = `BSIS_OFS_WRES; // winding resistance[6:0]
  localparam logic [7:0] OFS_VCON = `BSIS_OFS_VCON; // velocity constant[6:0]
  localparam logic [7:0] OFS_STAT = `BSIS_OFS_STAT; // state[2:0], position[5:3]
  localparam logic [7:0] OFS_SPD = `BSIS_OFS_SPD; // speed upper byte

  logic [7:0] optB, optC, optD, optE, optF, optG, windRes, velConst;
  logic [7:0] next_optB, next_optC, next_optD, next_optE, next_optF, next_optG;
  logic [7:0] next_windRes, next_velConst, next_regRdData;

  bsis_pkg::bsis_state_type state, next_state;
  logic [31:0] timer, next_timer;
  logic [2:0] pairIdx, next_pairIdx;
  logic [2:0] bestIdx, next_bestIdx;
  logic [23:0] bestTime, next_bestTime;
  logic [2:0] pos, next_pos;
  logic [`BSIS_SPEED_W-1:0] speed, next_speed;
  logic [`BSIS_SPEED_W-1:0] rate, next_rate;
  logic [15:0] vLimit, next_vLimit;
  logic [15:0] vApplied, next_vApplied;
  logic [15:0] duty, next_duty;
  logic [2:0] drvStep, next_drvStep;
  logic [`BSIS_SPEED_W-1:0] phaseAcc, next_phaseAcc;
  bsis_pkg::bsis_drive_type drv, next_drv;

  // field views
  logic [1:0] startCurrentSel;
  logic [2:0] rampRate, firstAccel, secondAccel, alignDur;
  logic [4:0] handoffThresh;
  logic [3:0] detThresh;
  logic releaseSel;
  logic [1:0] pulseSpacing, leadAngle;
  assign startCurrentSel = optB[1:0];
  assign rampRate = optB[4:2];
  assign firstAccel = optC[2:0];
  assign secondAccel = optC[5:3];
  assign handoffThresh = optD[4:0];
  assign alignDur = optE[2:0];
  assign detThresh = optF[3:0];
  assign releaseSel = optF[4];
  assign pulseSpacing = optF[6:5];
  assign leadAngle = optG[1:0];

  // status and speed views read back by software
  logic [7:0] statusWord, speedByte;
  assign statusWord = {2'h0, pos, state};
  assign speedByte = speed[`BSIS_SPEED_W-1:`BSIS_SPEED_W-8];

  // drive pattern for a step: high phase, low phase (six-step table)
  function automatic bsis_pkg::bsis_drive_type step_drive(input logic [2:0] s);
    bsis_pkg::bsis_drive_type d;
    d = '0;
    case (s)
      3'h0: begin
        d.high = 3'h2;
        d.low = 3'h4;
      end // VW
      3'h1: begin
        d.high = 3'h4;
        d.low = 3'h2;
      end // WV
      3'h2: begin
        d.high = 3'h1;
        d.low = 3'h2;
      end // UV
      3'h3: begin
        d.high = 3'h2;
        d.low = 3'h1;
      end // VU
      3'h4: begin
        d.high = 3'h4;
        d.low = 3'h1;
      end // WU
      default: begin
        d.high = 3'h1;
        d.low = 3'h4;
      end // UW
    endcase
    return d;
  endfunction

  // register writes and read data
  always_comb begin
    next_optB = optB;
    next_optC = optC;
    next_optD = optD;
    next_optE = optE;
    next_optF = optF;
    next_optG = optG;
    next_windRes = windRes;
    next_velConst = velConst;
    next_regRdData = 8'h00;
    if (regWrite) begin
      if (regAddr == OFS_B) next_optB = {3'h0, regWrData[4:0]};
      else if (regAddr == OFS_C) next_optC = {2'h0, regWrData[5:0]};
      else if (regAddr == OFS_D) next_optD = {3'h0, regWrData[4:0]};
      else if (regAddr == OFS_E) next_optE = {5'h0, regWrData[2:0]};
      else if (regAddr == OFS_F) next_optF = {1'h0, regWrData[6:0]};
      else if (regAddr == OFS_G) next_optG = {6'h0, regWrData[1:0]};
      else if (regAddr == OFS_WRES) next_windRes = {1'h0, regWrData[6:0]};
      else if (regAddr == OFS_VCON) next_velConst = {1'h0, regWrData[6:0]};
    end
    if (regRead) begin
      if (regAddr == OFS_B) next_regRdData = optB;
      else if (regAddr == OFS_C) next_regRdData = optC;
      else if (regAddr == OFS_D) next_regRdData = optD;
      else if (regAddr == OFS_E) next_regRdData = optE;
      else if (regAddr == OFS_F) next_regRdData = optF;
      else if (regAddr == OFS_G) next_regRdData = optG;
      else if (regAddr == OFS_WRES) next_regRdData = windRes;
      else if (regAddr == OFS_VCON) next_regRdData = velConst;
      else if (regAddr == OFS_STAT) next_regRdData = statusWord;
      else if (regAddr == OFS_SPD) next_regRdData = speedByte;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      optB <= 8'h00;
      optC <= 8'h00;
      optD <= 8'h00;
      optE <= 8'h00;
      optF <= 8'h00;
      optG <= 8'h00;
      windRes <= 8'h00;
      velConst <= 8'h00;
      regRdData <= 8'h00;
    end else begin
      optB <= next_optB;
      optC <= next_optC;
      optD <= next_optD;
      optE <= next_optE;
      optF <= next_optF;
      optG <= next_optG;
      windRes <= next_windRes;
      velConst <= next_velConst;
      regRdData <= next_regRdData;
    end
  end

  // sequencer next state
  logic [31:0] alignCycles, gapCycles;
  logic [7:0] iLimit;
  always_comb begin
    // align duration doubles per code step
    alignCycles = 32'(ALIGN_BASE_CYC) << alignDur;
    gapCycles = 32'(GAP_BASE_CYC) << {pulseSpacing, 1'b0};
    // current magnitude from the start current field
    iLimit = 8'(`BSIS_CURR_BASE) << startCurrentSel;
    next_state = state;
    next_timer = timer + 32'h1;
    next_pairIdx = pairIdx;
    next_bestIdx = bestIdx;
    next_bestTime = bestTime;
    next_pos = pos;
    next_speed = speed;
    next_rate = rate;
    next_drv = drv;
    next_drvStep = drvStep;
    next_phaseAcc = phaseAcc;
    case (state)
      bsis_pkg::BSIS_IDLE: begin
        next_drv = '0;
        next_timer = 32'h0;
        if (startReq) begin
          // clear timers and minimum before the run
          next_pairIdx = 3'h0;
          next_bestIdx = 3'h0;
          next_bestTime = `BSIS_PULSE_MAX;
          next_speed = '0;
          next_rate = '0;
          next_phaseAcc = '0;
          if (detThresh != 4'h0) begin
            next_state = bsis_pkg::BSIS_PULSE;
            next_drv = step_drive(3'h0);
          end else begin
            next_state = bsis_pkg::BSIS_ALIGN;
            // current into V and out of W
            next_drv = step_drive(3'h0);
          end
        end
      end
      bsis_pkg::BSIS_ALIGN: begin
        if (timer >= alignCycles - 32'h1) begin
          next_state = bsis_pkg::BSIS_ACCEL;
          next_timer = 32'h0;
          next_drvStep = 3'h1; // field stands along V, drive one step ahead
        end
      end
      bsis_pkg::BSIS_PULSE: begin
        if (currentAtThresh || timer[23:0] == `BSIS_PULSE_MAX) begin
          if (timer[23:0] < bestTime) begin
            next_bestTime = timer[23:0];
            next_bestIdx = pairIdx;
          end
          next_drv.high = 3'h0;
          next_drv.low = releaseSel ? 3'h0 : drv.low;
          next_timer = 32'h0;
          next_state = bsis_pkg::BSIS_GAP;
        end
      end
      bsis_pkg::BSIS_GAP: begin
        if (timer >= gapCycles - 32'h1) begin
          next_timer = 32'h0;
          next_drv = '0;
          if (pairIdx == `BSIS_NUM_PAIRS - 3'h1) begin
            next_state = bsis_pkg::BSIS_PICK;
          end else begin
            next_pairIdx = pairIdx + 3'h1;
            next_drv = step_drive(pairIdx + 3'h1);
            next_state = bsis_pkg::BSIS_PULSE;
          end
        end
      end
      bsis_pkg::BSIS_PICK: begin
        next_pos = bestIdx;
        // lead angle in 60 degree steps up to 180
        next_drvStep = 3'((4'(bestIdx) + 4'(leadAngle) + 4'h1) % 4'h6);
        next_state = bsis_pkg::BSIS_ACCEL;
        next_timer = 32'h0;
      end
      bsis_pkg::BSIS_ACCEL: begin
        // open loop commutation, no position feedback
        next_drv = step_drive(drvStep);
        if (timer >= 32'(STEP_CYC) - 32'h1) begin
          next_timer = 32'h0;
          // rate grows by second order, speed by rate plus first order
          next_rate = rate + (32'h1 << secondAccel);
          next_speed = speed + rate + (32'h1 << firstAccel);
          next_phaseAcc = phaseAcc + speed;
          if (phaseAcc[`BSIS_SPEED_W-1] != next_phaseAcc[`BSIS_SPEED_W-1])
            next_drvStep = (drvStep == 3'h5) ? 3'h0 : drvStep + 3'h1;
        end
        // hand over when speed exceeds it
        if (speed > (32'(handoffThresh) << `BSIS_HANDOFF_SHIFT)) begin
          next_state = bsis_pkg::BSIS_DONE;
        end
      end
      default: begin
        next_drv = '0;
      end
    endcase
    if (restartReq) begin
      next_state = bsis_pkg::BSIS_IDLE;
      next_drv = '0;
      next_timer = 32'h0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= bsis_pkg::BSIS_IDLE;
      timer <= 32'h0;
      pairIdx <= 3'h0;
      bestIdx <= 3'h0;
      bestTime <= `BSIS_PULSE_MAX;
      pos <= 3'h0;
      speed <= '0;
      rate <= '0;
      drv <= '0;
      drvStep <= 3'h0;
      phaseAcc <= '0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      pairIdx <= next_pairIdx;
      bestIdx <= next_bestIdx;
      bestTime <= next_bestTime;
      pos <= next_pos;
      speed <= next_speed;
      rate <= next_rate;
      drv <= next_drv;
      drvStep <= next_drvStep;
      phaseAcc <= next_phaseAcc;
    end
  end

  // voltage limit, ramp and duty
  logic [15:0] target, rampStep;
  logic [31:0] dutyWide;
  always_comb begin
    // current times resistance plus speed times constant
    // only the upper speed byte enters, which keeps the product small
    next_vLimit = 16'(iLimit * windRes[6:0]) + 16'(speedByte * velConst[6:0]);
    // ramp step from ramp rate field
    rampStep = 16'h1 << rampRate;
    target = (state == bsis_pkg::BSIS_ALIGN || state == bsis_pkg::BSIS_ACCEL) ? vLimit : 16'h0;
    // a big step is split so the torque rises gently
    if (target > vApplied && target - vApplied > rampStep) begin
      next_vApplied = vApplied + rampStep;
    end else if (target > vApplied) begin
      next_vApplied = target;
    end else begin
      next_vApplied = target;
    end
    // duty scales inversely with supply; a low supply saturates rather than wraps
    dutyWide = (32'(vApplied) << 8) / ((supplyLevel == 8'h0) ? 32'h1 : 32'(supplyLevel));
    next_duty = (dutyWide > 32'(`BSIS_DUTY_MAX)) ? `BSIS_DUTY_MAX : dutyWide[15:0];
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      vLimit <= 16'h0;
      vApplied <= 16'h0;
      duty <= 16'h0;
    end else begin
      vLimit <= next_vLimit;
      vApplied <= next_vApplied;
      duty <= next_duty;
    end
  end

  // outputs
  assign phaseHigh = drv.high;
  assign phaseLow = drv.low;
  assign currentThresh = detThresh;
  // limit active in align and acceleration
  assign currentLimit = (state == bsis_pkg::BSIS_ALIGN || state == bsis_pkg::BSIS_ACCEL)
                        ? iLimit : 8'h00;
  assign dutyOut = duty;
  assign driveState = drvStep;
  assign closedLoopGo = (state == bsis_pkg::BSIS_DONE);
  assign busy = (state != bsis_pkg::BSIS_IDLE) && (state != bsis_pkg::BSIS_DONE);
endmodule
`default_nettype wire

// File: pkg/bsis_params.svh
// constants for the start-up initialization sequencer
// Operation
// - align drives current into V out of W
// - align current magnitude from start current field
// - detection enabled when threshold field nonzero
// - pulse pairs VW WV UV VU WU UW
// - pulse ends when current reaches threshold
// - count cycles from voltage to threshold
// - shortest pulse time selects rotor state
// - release bit 0 keeps low side on
// - release bit 1 turns both switches off
// - spacing field separates successive pulses
// - start drive ahead by lead angle; the code adds it only after detection, after align it drives one step ahead
// - open loop drive without position feedback
// - open loop ends at handoff threshold
// - align duration field spans 40ms to 5.12s
// - speed grows by first and second order
// - start current limit during start phases
// - voltage limit is current times resistance plus speed
// - start voltage rise limited by ramp rate
// - zero threshold selects align, then accelerate
// - accelerate until speed exceeds threshold, then hand over
`ifndef BSIS_PARAMS_SVH
`define BSIS_PARAMS_SVH
`define BSIS_CLK_MHZ 250
`define BSIS_ALIGN_BASE_MS 40
`define BSIS_ALIGN_BASE_CYC (`BSIS_ALIGN_BASE_MS * 1000 * `BSIS_CLK_MHZ)
`define BSIS_STEP_US 100
`define BSIS_STEP_CYC (`BSIS_STEP_US * `BSIS_CLK_MHZ)
`define BSIS_GAP_BASE_US 10
`define BSIS_GAP_BASE_CYC (`BSIS_GAP_BASE_US * `BSIS_CLK_MHZ)
`define BSIS_PULSE_MAX 24'hFFFFFF
`define BSIS_SPEED_W 32
`define BSIS_RATE_FRAC 16
`define BSIS_HANDOFF_SHIFT 20
`define BSIS_CURR_BASE 8'h10 // largest code still fits the 8-bit limit
`define BSIS_DUTY_MAX 16'hFFFF
`define BSIS_NUM_PAIRS 3'h6
`define BSIS_OFS_B 8'h00
`define BSIS_OFS_C 8'h01
`define BSIS_OFS_D 8'h02
`define BSIS_OFS_E 8'h03
`define BSIS_OFS_F 8'h04
`define BSIS_OFS_G 8'h05
`define BSIS_OFS_WRES 8'h06
`define BSIS_OFS_VCON 8'h07
`define BSIS_OFS_STAT 8'h08
`define BSIS_OFS_SPD 8'h09
`endif

// File: pkg/bsis_pkg.sv
// types for the start-up initialization sequencer
`default_nettype none
package bsis_pkg;
  typedef enum logic [2:0] {
    BSIS_IDLE, BSIS_ALIGN, BSIS_PULSE, BSIS_GAP, BSIS_PICK, BSIS_ACCEL, BSIS_DONE
  } bsis_state_type;
  // phase drive: high switch on, low switch on per phase U,V,W
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } bsis_drive_type;
endpackage
`default_nettype wire

// File: tb/bsis_checker.sv
// port-level assertions for the start-up sequencer
`timescale 1ns/100ps
`default_nettype none
module bsis_checker #(
  parameter int ALIGN_BASE_CYC = 20,
  parameter int STEP_CYC = 4,
  parameter int GAP_BASE_CYC = 4
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic startReq,
  input wire logic restartReq,
  input wire logic currentAtThresh,
  input wire logic [7:0] supplyLevel,
  input wire logic [2:0] phaseHigh,
  input wire logic [2:0] phaseLow,
  input wire logic [3:0] currentThresh,
  input wire logic [7:0] currentLimit,
  input wire logic [15:0] dutyOut,
  input wire logic [2:0] driveState,
  input wire logic closedLoopGo,
  input wire logic busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic relBit;
  logic next_relBit;
  logic [3:0] lowNib;
  assign lowNib = regWrData[3:0];
  // release bit shadow, since the field has no port of its own
  always_comb begin
    next_relBit = relBit;
    if (regWrite && regAddr == 8'h04) next_relBit = regWrData[4];
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) relBit <= 1'b0;
    else relBit <= next_relBit;
  end
  a_start_pair: assert property (!busy && !closedLoopGo && startReq && !restartReq
    |-> ##[1:2] (phaseHigh == 3'h2 && phaseLow == 3'h4)) else $error("first drive not VW");
  a_no_shoot: assert property ((phaseHigh & phaseLow) == 3'h0)
    else $error("high and low on together");
  a_thresh_mirror: assert property (regWrite && regAddr == 8'h04
    |=> currentThresh == $past(lowNib)) else $error("threshold output stale");
  a_pulse_release: assert property (busy && currentAtThresh && phaseHigh != 3'h0 &&
    !restartReq |=> phaseHigh == 3'h0 && phaseLow == (relBit ? 3'h0 : $past(phaseLow)))
    else $error("pulse release wrong");
  a_abort_restart: assert property (restartReq
    |-> ##[1:2] (!busy && phaseHigh == 3'h0 && phaseLow == 3'h0)) else $error("restart ignored");
  a_handoff_holds: assert property (closedLoopGo && !restartReq |=> closedLoopGo)
    else $error("handoff dropped");
  a_idle_quiet: assert property (!busy && !$past(busy) && !closedLoopGo &&
    !$past(closedLoopGo) |-> phaseHigh == 3'h0 && currentLimit == 8'h00)
    else $error("drive while idle");
  a_handoff_from_run: assert property ($rose(closedLoopGo) |-> $past(busy))
    else $error("handoff without run");
  c_handoff: cover property ($rose(closedLoopGo));
  c_abort: cover property (restartReq && busy);
  c_pulse_end: cover property (currentAtThresh && phaseHigh != 3'h0);
endmodule
bind bsis_sequencer bsis_checker #(
  .ALIGN_BASE_CYC(ALIGN_BASE_CYC), .STEP_CYC(STEP_CYC), .GAP_BASE_CYC(GAP_BASE_CYC)
) i_bsis_checker (
  .ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .startReq(startReq),
  .restartReq(restartReq), .currentAtThresh(currentAtThresh), .supplyLevel(supplyLevel),
  .phaseHigh(phaseHigh), .phaseLow(phaseLow), .currentThresh(currentThresh),
  .currentLimit(currentLimit), .dutyOut(dutyOut), .driveState(driveState),
  .closedLoopGo(closedLoopGo), .busy(busy)
);
`default_nettype wire

// File: tb/bsis_power_stage.sv
// power stage and winding model: current rise per phase pair
`timescale 1ns/100ps
`default_nettype none
module bsis_power_stage (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [2:0] phaseHigh,
  input wire logic [2:0] phaseLow,
  input wire logic enable,
  input wire logic [2:0] fastPair,
  output logic currentAtThresh
);
  logic [3:0] rise;
  logic [3:0] next_rise;
  logic [3:0] need;
  logic [2:0] pairIdx;
  logic next_flag;
  // conducting pair; no path means the current has gone
  always_comb begin
    case ({phaseHigh, phaseLow})
      6'h14: pairIdx = 3'h0;
      6'h22: pairIdx = 3'h1;
      6'h0A: pairIdx = 3'h2;
      6'h11: pairIdx = 3'h3;
      6'h21: pairIdx = 3'h4;
      6'h0C: pairIdx = 3'h5;
      default: pairIdx = 3'h7;
    endcase
    need = (pairIdx == fastPair) ? 4'h3 : 4'h6 + {1'b0, pairIdx};
    next_rise = rise;
    if (!enable || pairIdx == 3'h7) next_rise = 4'h0;
    else if (rise != 4'hF) next_rise = rise + 4'h1;
    // flag drops once the high side lets go
    next_flag = enable && pairIdx != 3'h7 && next_rise >= need;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) rise <= 4'h0;
    else rise <= next_rise;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) currentAtThresh <= 1'b0;
    else currentAtThresh <= next_flag;
  end
endmodule
`default_nettype wire

// File: tb/bsis_sequencer_tb_top.sv
// self-checking bench for the start-up sequencer
`timescale 1ns/100ps
`default_nettype none
module bsis_sequencer_tb_top;
  localparam int GAP = 4;
  localparam logic [5:0] ORDER [6] = '{6'h14, 6'h22, 6'h0A, 6'h11, 6'h21, 6'h0C};
  localparam logic [7:0] MASK [8] = '{8'h1F, 8'h3F, 8'h1F, 8'h07, 8'h7F, 8'h03, 8'h7F, 8'h7F};
  logic ref_clk, arst_n, regWrite, regRead, startReq, restartReq, currentAtThresh;
  logic [7:0] regAddr, regWrData, regRdData, currentLimit, d;
  logic [2:0] phaseHigh, phaseLow, driveState, prevHigh;
  logic [3:0] currentThresh;
  logic [15:0] dutyOut;
  logic closedLoopGo, busy, watch;
  int failures, comparisons, t0, t1, g0, g1;
  int cyc = 0;
  logic [5:0] pairs[$];
  int starts[$];
  int ends[$];
  bsis_sequencer #(.ALIGN_BASE_CYC(20), .STEP_CYC(4), .GAP_BASE_CYC(GAP)) i_bsis_sequencer (
    .ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .startReq(startReq),
    .restartReq(restartReq), .currentAtThresh(currentAtThresh), .supplyLevel(8'hC0),
    .phaseHigh(phaseHigh), .phaseLow(phaseLow), .currentThresh(currentThresh),
    .currentLimit(currentLimit), .dutyOut(dutyOut), .driveState(driveState),
    .closedLoopGo(closedLoopGo), .busy(busy));
  bsis_power_stage i_bsis_power_stage (.ref_clk(ref_clk), .arst_n(arst_n),
    .phaseHigh(phaseHigh), .phaseLow(phaseLow), .enable(watch), .fastPair(3'h3),
    .currentAtThresh(currentAtThresh));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // pulse starts and ends, timed in cycles; stops after six
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    prevHigh <= phaseHigh;
    if (watch && prevHigh == 3'h0 && phaseHigh != 3'h0) begin
      pairs.push_back({phaseHigh, phaseLow});
      starts.push_back(cyc);
    end
    if (watch && prevHigh != 3'h0 && phaseHigh == 3'h0) begin
      ends.push_back(cyc);
      if (ends.size() == 6) watch <= 1'b0;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    v = regRdData;
  endtask
  // one-cycle start or restart strobe, then let the outputs settle
  task automatic kick(input logic abort);
    @(posedge ref_clk);
    if (abort) restartReq <= 1'b1;
    else startReq <= 1'b1;
    @(posedge ref_clk);
    restartReq <= 1'b0;
    startReq <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic align_run(input logic [7:0] thr, output int n);
    wr(8'h04, 8'h00);
    wr(8'h03, 8'h01);
    wr(8'h02, thr);
    kick(1'b0);
    check("align drive", {phaseHigh, phaseLow}, 6'h14);
    check("limit on", currentLimit != 8'h00, 1'b1);
    rd(8'h08, d);
    check("align state", d[2:0], 3'h1);
    repeat (25) @(posedge ref_clk);
    #1;
    check("align held", {phaseHigh, phaseLow}, 6'h14);
    check("duty ramped", dutyOut > 16'h0 && dutyOut < 16'h0400, 1'b1);
    n = 0;
    while (closedLoopGo !== 1'b1 && n < 20000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("handoff", closedLoopGo, 1'b1);
    kick(1'b1);
    check("idle after", {busy, closedLoopGo}, 2'h0);
  endtask
  task automatic detect_run(input logic rel, input logic [1:0] spc, output int gap);
    int n;
    pairs.delete();
    starts.delete();
    ends.delete();
    wr(8'h04, {1'b0, spc, rel, 4'h5});
    watch <= 1'b1;
    kick(1'b0);
    n = 0;
    while (watch === 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("pulse count", ends.size(), 6);
    for (int i = 0; i < 6; i++) check("pair", pairs[i], ORDER[i]);
    gap = starts[1] - ends[0];
    // the last gap and the pick still run after the sixth pulse
    repeat (40) @(posedge ref_clk);
    rd(8'h08, d);
    check("picked", d[5:3], 3'h3);
    check("open loop", d[2:0], 3'h5);
    kick(1'b1);
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard well past the expected run length
  initial begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    tally_and_finish;
  end
  initial begin
    {regAddr, regWrData, regWrite, regRead, startReq, restartReq, watch} = '0;
    arst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    check("reset drive", {phaseHigh, phaseLow, busy, closedLoopGo}, 0);
    check("reset limit", {currentLimit, dutyOut}, 0);
    for (int i = 0; i < 8; i++) begin
      wr(i[7:0], 8'hFF);
      rd(i[7:0], d);
      check("field mask", d, MASK[i]);
    end
    check("thresh out", currentThresh, 4'hF);
    wr(8'h08, 8'hFF);
    rd(8'h08, d);
    check("status ro", d, 8'h00);
    wr(8'h0A, 8'h5A);
    rd(8'h0A, d);
    check("unmapped", d, 8'h00);
    wr(8'h00, 8'h13);
    wr(8'h01, 8'h3F);
    wr(8'h05, 8'h00);
    align_run(8'h00, t0);
    align_run(8'h01, t1);
    check("later handoff", t1 > t0, 1'b1);
    detect_run(1'b0, 2'h0, g0);
    detect_run(1'b1, 2'h1, g1);
    check("gap step", g1 - g0, (GAP << 2) - GAP);
    // abort a detection run in a long gap
    wr(8'h04, 8'h65);
    watch <= 1'b1;
    kick(1'b0);
    repeat (20) @(posedge ref_clk);
    kick(1'b1);
    check("aborted", {busy, phaseHigh, phaseLow}, 7'h00);
    tally_and_finish;
  end
endmodule
`default_nettype wire
